// ==== logic/crp_gen.sv ====
// Summary of operation
// - slot page: code 80h, byte 1 reserved
// - slot page length field is 24
// - reserved handler or slot: reservation conflict instead
// - slot vertical bounds and position, bytes 4-15
// - slot horizontal bounds and position, bytes 16-27
// - sensor page: code 81h, sixteen bytes
// - sensor page length field is 12
// - sensor bounds and position, bytes 4-15
// - eject page: code 82h, sixteen bytes
// - eject page length 12, bounds and position
// - stop at lesser of allocation, page size

////////////////////////////////////////////////////////////////////////
// byte fifo between page builder and data-in output stage
module crp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // elaboration check: the wrap-bit full test needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("crp_fifo depth must be a power of two");

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  wr_next;
  logic [AW:0]  rd_reg;
  logic [AW:0]  rd_next;
  logic         push;
  logic         pop;

  // full when pointers differ only in the wrap bit
  always_comb begin
    in_ready  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
    out_valid = wr_reg != rd_reg;
    out_data  = mem[rd_reg[AW-1:0]];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_next   = push ? wr_reg + 1'b1 : wr_reg;
    rd_next   = pop ? rd_reg + 1'b1 : rd_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // storage carries no reset; pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// calibration result page builder
module crp_gen
  import crp_pkg::*;
#(
  parameter int FIFO_DEPTH = CRP_FIFO_DEP
) (
  // clock and reset
  input  wire logic            CORE_CLK,
  input  wire logic            RST,
  // request from the command decoder
  input  wire logic            START,
  input  wire crp_req_t        REQ,
  input  wire logic            HANDLER_RESERVED,
  input  wire logic            SLOT_RESERVED,
  // calibration results
  input  wire crp_slot_t       CAL_SLOT,
  input  wire crp_trip_t       CAL_SENS,
  input  wire crp_trip_t       CAL_EJECT,
  // data-in byte stream
  output logic [7:0]           XFER_DATA,
  output logic                 XFER_VALID,
  input  wire logic            XFER_READY,
  // completion
  output logic                 BUSY,
  output logic                 DONE,
  output logic                 CONFLICT,
  output logic                 BAD_PAGE
);
  // elaboration check on the buffer depth
  if (FIFO_DEPTH < 2) $error("crp_gen fifo depth too small");

  // byte of a page at a given position; fields msb first
  function automatic logic [7:0] page_byte(logic [7:0] pg, logic [15:0] idx, crp_slot_t v);
    logic [31:0] w;
    logic [15:0] len;
    logic [7:0]  b;
    len = (pg == CRP_PG_SLOT) ? CRP_LEN_SLOT : CRP_LEN_TRIP;
    unique case (idx[4:2])
      3'h1:    w = v.vert.upper;
      3'h2:    w = v.vert.lower;
      3'h3:    w = v.vert.calib;
      3'h4:    w = v.horiz.upper;
      3'h5:    w = v.horiz.lower;
      3'h6:    w = v.horiz.calib;
      default: w = 32'h0000_0000;
    endcase
    unique case (idx[1:0])
      2'h0:    b = w[31:24];
      2'h1:    b = w[23:16];
      2'h2:    b = w[15:8];
      default: b = w[7:0];
    endcase
    if (idx == CRP_IDX_CODE) begin
      b = pg;
    end else if (idx == CRP_IDX_RSVD) begin
      b = 8'h00;
    end else if (idx == CRP_IDX_LENHI) begin
      b = len[15:8];
    end else if (idx == CRP_IDX_LENLO) begin
      b = len[7:0];
    end
    return b;
  endfunction

  crp_state_t  state_reg;
  crp_state_t  state_next;
  logic [15:0] idx_reg;
  logic [15:0] idx_next;
  logic [15:0] total_reg;
  logic [15:0] total_next;
  logic [7:0]  page_reg;
  logic [7:0]  page_next;
  crp_slot_t   vals_reg;
  crp_slot_t   vals_next;
  logic        done_next;
  logic        conf_next;
  logic        bad_next;
  logic        busy_next;
  logic        done_reg;
  logic        conf_reg;
  logic        bad_reg;
  logic        busy_reg;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;
  logic        push;
  logic [7:0]  push_data;
  logic        dv_reg;
  logic        dv_next;
  logic [7:0]  dd_reg;
  logic [7:0]  dd_next;
  logic [15:0] page_size;
  logic        known;

  ////////////////////////////////////////////////////////////////////
  // page sequencer; inputs come from same-clock logic, no sync
  always_comb begin
    known      = REQ.page == CRP_PG_SLOT || REQ.page == CRP_PG_SENS ||
                 REQ.page == CRP_PG_EJECT;
    page_size  = CRP_HDR_BYTES +
                 ((REQ.page == CRP_PG_SLOT) ? CRP_LEN_SLOT : CRP_LEN_TRIP);
    push       = state_reg == CRP_SEND && fifo_in_ready;
    push_data  = page_byte(page_reg, idx_reg, vals_reg);
    state_next = state_reg;
    idx_next   = idx_reg;
    total_next = total_reg;
    page_next  = page_reg;
    vals_next  = vals_reg;
    done_next  = 1'b0;
    conf_next  = 1'b0;
    bad_next   = 1'b0;
    unique case (state_reg)
      CRP_IDLE: begin
        if (START) begin
          if (!known) begin
            bad_next = 1'b1;
          end else if (REQ.page == CRP_PG_SLOT && (HANDLER_RESERVED || SLOT_RESERVED)) begin
            conf_next = 1'b1;
          end else if (REQ.alloc == 16'h0000) begin
            done_next = 1'b1;  // nothing allowed, finish with no data
          end else begin
            state_next = CRP_SEND;
            idx_next   = 16'h0000;
            page_next  = REQ.page;
            total_next = (REQ.alloc < page_size) ? REQ.alloc : page_size;
            // snapshot so a late recalibration cannot tear a page
            if (REQ.page == CRP_PG_SLOT) begin
              vals_next = CAL_SLOT;
            end else begin
              vals_next.vert  = (REQ.page == CRP_PG_SENS) ? CAL_SENS : CAL_EJECT;
              vals_next.horiz = '0;
            end
          end
        end
      end
      CRP_SEND: begin
        if (push) begin
          idx_next = idx_reg + 16'h0001;
          if (idx_next == total_reg) begin
            state_next = CRP_DRAIN;
          end
        end
      end
      CRP_DRAIN: begin
        // done only once the last byte has left the output stage
        if (!fifo_out_valid && (!dv_reg || XFER_READY)) begin
          state_next = CRP_IDLE;
          done_next  = 1'b1;
        end
      end
    endcase
    busy_next = state_next != CRP_IDLE;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= CRP_IDLE;
      idx_reg   <= '0;
      total_reg <= '0;
      page_reg  <= '0;
      vals_reg  <= '0;
      done_reg  <= 1'b0;
      conf_reg  <= 1'b0;
      bad_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      total_reg <= total_next;
      page_reg  <= page_next;
      vals_reg  <= vals_next;
      done_reg  <= done_next;
      conf_reg  <= conf_next;
      bad_reg   <= bad_next;
      busy_reg  <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // byte fifo; a stalled initiator stalls the sequencer through in_ready
  crp_fifo #(
    .W     (CRP_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // output stage keeps the stream outputs on flip-flops
  always_comb begin
    fifo_pop = !dv_reg || XFER_READY;
    dv_next  = fifo_pop ? fifo_out_valid : dv_reg;
    dd_next  = (fifo_pop && fifo_out_valid) ? fifo_out_data : dd_reg;
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dv_reg <= 1'b0;
      dd_reg <= 8'h00;
    end else begin
      dv_reg <= dv_next;
      dd_reg <= dd_next;
    end
  end

  assign XFER_DATA  = dd_reg;
  assign XFER_VALID = dv_reg;
  assign BUSY       = busy_reg;
  assign DONE       = done_reg;
  assign CONFLICT   = conf_reg;
  assign BAD_PAGE   = bad_reg;

  ////////////////////////////////////////////////////////////////////
  // checks on the bytes pushed and on the sequence
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  slot_code_a: assert property (push && idx_reg == CRP_IDX_CODE &&
    page_reg == CRP_PG_SLOT |-> push_data == 8'h80) else $error("slot page code wrong");
  slot_len_a: assert property (push && idx_reg == CRP_IDX_LENLO &&
    page_reg == CRP_PG_SLOT |-> push_data == 8'd24) else $error("slot length wrong");
  slot_conflict_a: assert property (state_reg == CRP_IDLE && START &&
    REQ.page == CRP_PG_SLOT && (HANDLER_RESERVED || SLOT_RESERVED) |=>
    CONFLICT && state_reg == CRP_IDLE ##1 !XFER_VALID) else $error("conflict not reported");
  slot_vert_a: assert property (push && idx_reg == CRP_IDX_F1 &&
    page_reg == CRP_PG_SLOT |-> push_data == vals_reg.vert.upper[31:24])
    else $error("vertical field misplaced");
  slot_horiz_a: assert property (push && idx_reg == CRP_IDX_F4 &&
    page_reg == CRP_PG_SLOT |-> push_data == vals_reg.horiz.upper[31:24])
    else $error("horizontal field misplaced");
  // an allocation of exactly one page must still see the full sixteen bytes
  sens_code_a: assert property (state_reg == CRP_IDLE && START &&
    REQ.page == CRP_PG_SENS && REQ.alloc >= 16'd16 |=>
    total_reg == 16'd16 && page_reg == 8'h81) else $error("sensor page size wrong");
  sens_len_a: assert property (push && idx_reg == CRP_IDX_LENLO &&
    page_reg == CRP_PG_SENS |-> push_data == 8'd12) else $error("sensor length wrong");
  sens_field_a: assert property (push && idx_reg == CRP_IDX_F3 &&
    page_reg == CRP_PG_SENS |-> push_data == vals_reg.vert.calib[31:24])
    else $error("sensor field misplaced");
  eject_code_a: assert property (push && idx_reg == CRP_IDX_CODE &&
    page_reg == CRP_PG_EJECT |-> push_data == 8'h82) else $error("eject page code wrong");
  eject_len_a: assert property (push && idx_reg == CRP_IDX_LENLO &&
    page_reg == CRP_PG_EJECT |-> push_data == 8'd12) else $error("eject length wrong");
  xfer_count_a: assert property (push && idx_reg + 16'd1 == total_reg |=>
    state_reg == CRP_DRAIN ##0 !push) else $error("transfer length wrong");
  rsvd_zero_a: assert property (push && idx_reg == CRP_IDX_RSVD |->
    push_data == 8'h00) else $error("reserved byte not zero");

  slot_page_c: cover property (state_reg == CRP_SEND && page_reg == CRP_PG_SLOT ##[1:300] DONE);
  short_alloc_c: cover property (START && REQ.alloc == 16'd3 && state_reg == CRP_IDLE
    ##[1:50] DONE);
  conflict_c: cover property (CONFLICT);
  stall_full_c: cover property (state_reg == CRP_SEND && !fifo_in_ready);
endmodule

// ==== logic/crp_pkg.sv ====
package crp_pkg;
  // page codes of the three calibration result pages
  localparam logic [7:0]  CRP_PG_SLOT   = 8'h80;
  localparam logic [7:0]  CRP_PG_SENS   = 8'h81;
  localparam logic [7:0]  CRP_PG_EJECT  = 8'h82;
  // page length field values; the header adds four bytes
  localparam logic [15:0] CRP_LEN_SLOT  = 16'h0018;
  localparam logic [15:0] CRP_LEN_TRIP  = 16'h000C;
  localparam logic [15:0] CRP_HDR_BYTES = 16'h0004;
  // header byte positions
  localparam logic [15:0] CRP_IDX_CODE  = 16'h0000;
  localparam logic [15:0] CRP_IDX_RSVD  = 16'h0001;
  localparam logic [15:0] CRP_IDX_LENHI = 16'h0002;
  localparam logic [15:0] CRP_IDX_LENLO = 16'h0003;
  // first byte of the first, third and fourth four-byte fields, msb first
  localparam logic [15:0] CRP_IDX_F1    = 16'h0004;
  localparam logic [15:0] CRP_IDX_F3    = 16'h000C;
  localparam logic [15:0] CRP_IDX_F4    = 16'h0010;
  // fifo shape
  localparam int          CRP_BYTE_W    = 8;
  localparam int          CRP_FIFO_DEP  = 16;

  // one bound / bound / calibrated triple
  typedef struct packed {
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] calib;
  } crp_trip_t;

  // drive-slot results: vertical then horizontal
  typedef struct packed {
    crp_trip_t vert;
    crp_trip_t horiz;
  } crp_slot_t;

  // request from the command decoder
  typedef struct packed {
    logic [7:0]  page;
    logic [15:0] alloc;
  } crp_req_t;

  typedef enum {CRP_IDLE, CRP_SEND, CRP_DRAIN} crp_state_t;
endpackage

// ==== sim/crp_init_model.sv ====
////////////////////////////////////////////////////////////////////////
// initiator side of the data-in phase: takes bytes, may stall
module crp_init_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // data-in byte stream
  input  wire logic [7:0] data,
  input  wire logic       valid,
  output logic            ready,
  // bench control: slow acceptance
  input  wire logic       stall
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rx_q[$];
  logic [1:0] phase_reg;
  logic       held_reg;
  logic [7:0] held_data_reg;
  int         hold_errors = 0;

  // a slow initiator takes one byte in four, so the fifo backs up
  assign ready = stall ? (phase_reg == 2'h3) : 1'b1;

  // capture accepted bytes; a byte offered must stand until it is taken
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
      held_reg  <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (held_reg && (valid !== 1'b1 || data !== held_data_reg))
        hold_errors++;
      if (valid && ready)
        rx_q.push_back(data);
      held_reg      <= valid && !ready;
      held_data_reg <= data;
    end
  end
endmodule

// ==== sim/tb_calibration_result_pages.sv ====
////////////////////////////////////////////////////////////////////////
// self-checking bench for the calibration result page builder
module tb_calibration_result_pages;
  import crp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk = 1'b0;
  logic       rst      = 1'b1;
  logic       start    = 1'b0;
  crp_req_t   req      = '0;
  logic       hres     = 1'b0;
  logic       sres     = 1'b0;
  logic       stall    = 1'b0;
  crp_slot_t  slot_v   = 192'h0102030405060708090A0B0C0D0E0F101112131415161718;
  crp_trip_t  sens_v   = 96'hA1A2A3A4A5A6A7A8A9AAABAC;
  crp_trip_t  ejct_v   = 96'hB1B2B3B4B5B6B7B8B9BABBBC;
  logic [7:0] xfer_data;
  logic       xfer_valid;
  logic       xfer_ready;
  logic       busy;
  logic       done;
  logic       conflict;
  logic       bad_page;
  int         num_errors  = 0;
  int         comparisons = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  crp_gen #(.FIFO_DEPTH(16)) dut (
    .CORE_CLK(core_clk), .RST(rst), .START(start), .REQ(req),
    .HANDLER_RESERVED(hres), .SLOT_RESERVED(sres), .CAL_SLOT(slot_v),
    .CAL_SENS(sens_v), .CAL_EJECT(ejct_v), .XFER_DATA(xfer_data),
    .XFER_VALID(xfer_valid), .XFER_READY(xfer_ready), .BUSY(busy),
    .DONE(done), .CONFLICT(conflict), .BAD_PAGE(bad_page)
  );

  crp_init_model m (
    .clk(core_clk), .rst(rst), .data(xfer_data), .valid(xfer_valid),
    .ready(xfer_ready), .stall(stall)
  );

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // expected page byte, fields msb first straight after the header
  function automatic logic [7:0] eb(input logic [7:0] pg, input int i);
    if (i == 0) return pg;
    if (i == 1 || i == 2) return 8'h00;
    if (i == 3) return (pg == 8'h80) ? 8'h18 : 8'h0C;
    if (pg == 8'h80) return slot_v[191 - 8 * (i - 4) -: 8];
    if (pg == 8'h81) return sens_v[95 - 8 * (i - 4) -: 8];
    return ejct_v[95 - 8 * (i - 4) -: 8];
  endfunction

  // one request; outc 0 data or empty, 1 conflict, 2 unknown page
  task automatic run_page(input logic [7:0] pg, input logic [15:0] al,
                          input logic hr, input logic sr, input logic st,
                          input int outc);
    int n;
    int sz;
    int nb;
    sz = (pg == 8'h80) ? 28 : 16;
    nb = (outc != 0) ? 0 : ((al < sz) ? al : sz);
    m.rx_q.delete();
    @(posedge core_clk);
    #1;
    stall = st;
    start = 1'b1;
    req   = '{page: pg, alloc: al};
    hres  = hr;
    sres  = sr;
    @(posedge core_clk);
    #1;
    start = 1'b0;
    check(busy, nb != 0);
    n = 0;
    while (done !== 1'b1 && conflict !== 1'b1 && bad_page !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(done, outc == 0);
    check(conflict, outc == 1);
    check(bad_page, outc == 2);
    repeat (3) @(posedge core_clk);
    #1;
    check(xfer_valid, 1'b0);
    check(m.rx_q.size(), nb);
    for (int i = 0; i < nb; i++)
      check(m.rx_q[i], eb(pg, i));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_slot();
    // slow initiator so the fifo fills and refuses, then drains
    run_page(8'h80, 16'h001C, 1'b0, 1'b0, 1'b1, 0);
    $display("test slot page done");
  endtask

  task automatic test_sensor();
    run_page(8'h81, 16'h0010, 1'b0, 1'b0, 1'b0, 0);
    // reservations only gate the slot page
    run_page(8'h81, 16'h0010, 1'b1, 1'b1, 1'b0, 0);
    $display("test sensor page done");
  endtask

  task automatic test_eject();
    run_page(8'h82, 16'h0100, 1'b0, 1'b0, 1'b1, 0);
    $display("test eject page done");
  endtask

  task automatic test_trunc();
    run_page(8'h80, 16'h0005, 1'b0, 1'b0, 1'b0, 0);
    run_page(8'h80, 16'h001B, 1'b0, 1'b0, 1'b1, 0);
    run_page(8'h82, 16'h0000, 1'b0, 1'b0, 1'b0, 0);
    $display("test truncation done");
  endtask

  task automatic test_refusals();
    run_page(8'h80, 16'h001C, 1'b1, 1'b0, 1'b0, 1);
    run_page(8'h80, 16'h001C, 1'b0, 1'b1, 1'b0, 1);
    run_page(8'h83, 16'h001C, 1'b0, 1'b0, 1'b0, 2);
    run_page(8'h7F, 16'h001C, 1'b1, 1'b0, 1'b0, 2);
    check(m.hold_errors, 0);
    $display("test refusals done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: reset held three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    test_slot();
    test_sensor();
    test_eject();
    test_trunc();
    test_refusals();
    tally_and_finish();
  end

  // watchdog: the run needs well under 2000 cycles
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule
